// ==== dv/tb.sv ====
// testbench: drives the sequencer pins and checks target and fault latch
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vcfs_pkg::*;
  logic clk = 0, rst_n = 0, bat = 0, on = 0, hv = 0;
  logic overvoltage_protect = 0, ov = 0, uv = 0, th = 0;
  logic [4:0] code = 5'h00;
  logic [1:0] slp = 2'h0;
  logic [3:0] sel = 4'h0;
  wire logic [4:0] vid;
  wire logic [1:0] sr, mj, mn;
  wire logic en;
  logic [6:0] dac, last = 7'h00;
  logic fl, tm, ol, bl, sw;
  logic [1:0] lo, hi;
  int errors = 0, n_compared = 0, cyc = 0;
  always #20 clk = ~clk;
  vcfs_host host (.battery_ok_in(bat), .want_on_in(on), .code_in(code),
    .sleep_in(slp), .sel_in(sel), .vid_out(vid), .sleep_out(sr),
    .major_out(mj), .minor_out(mn), .enable_out(en));
  vcfs_core dut (.clk_in(clk), .rst_n_in(rst_n), .vid_code_bits_in(vid),
    .suspend_select_minor_in(mn), .suspend_select_major_in(mj),
    .sleep_range_input_in(sr), .enable_n_pin_in(en),
    .test_hv_detect_in(hv), .overvoltage_protect_in(overvoltage_protect),
    .ov_fault_in(ov), .uv_fault_in(uv), .thermal_flag_in(th),
    .dac_code_out(dac), .fault_latch_out(fl), .test_mode_out(tm),
    .overlap_en_out(ol), .uv_blank_out(bl), .low_side_gate_out(lo),
    .high_side_gate_out(hi), .switching_out(sw));
  task automatic chk(input string nm, input logic [6:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // bounded wait for the ramp, then compare the target
  task automatic reach(input logic [6:0] g);
    int k;
    k = 0;
    while (dac !== g && k < 300) begin
      tick(1);
      k++;
    end
    chk("dac", dac, g);
  endtask : reach
  task automatic toggle_en;
    on = 0;
    tick(5);
    on = 1;
    tick(5);
  endtask : toggle_en
  task automatic end_sim;
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // settled sample mid-cycle; a jump of more than one step is a fault
  always @(negedge clk) begin
    if (rst_n && dac != last) chk("dac step", (dac > last) ? dac - last : last - dac, 7'h01);
    last = dac;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    tick(12);
    rst_n = 1;
    on = 1;
    tick(10);
    chk("dac no battery", dac, DAC_ZERO);
    chk("switching off", sw, 1'b0);
    chk("overlap on", ol, 1'b1);
    bat = 1;
    reach(VID_TOP);
    code = 5'h01;
    reach(7'h3d);
    code = 5'h1e;
    reach(7'h20);
    code = 5'h1f;
    reach(DAC_ZERO);
    slp = 2'h2;
    sel = 4'hf;
    reach(SUS_LOW_BASE + 7'h0f);
    sel = 4'h6;
    reach(SUS_LOW_BASE + 7'h06);
    slp = 2'h1;
    sel = 4'h0;
    reach(SUS_UP_BASE);
    sel = 4'he;
    reach(SUS_UP_BASE + 7'h0e);
    slp = 2'h3;
    tick(10);
    chk("dac sleep code 3", dac, SUS_UP_BASE + 7'h0e);
    slp = 2'h0;
    code = 5'h00;
    reach(VID_TOP);
    uv = 1;
    chk("blank", bl, 1'b1);
    tick(12);
    chk("latch blanked", fl, 1'b0);
    tick(20);
    chk("latch uv", fl, 1'b1);
    uv = 0;
    code = 5'h04;
    reach(DAC_ZERO);
    tick(3);
    chk("low gates", lo, 2'h3);
    chk("high gates", hi, 2'h0);
    chk("switching parked", sw, 1'b0);
    tick(30);
    chk("latch held", fl, 1'b1);
    toggle_en();
    chk("latch cleared", fl, 1'b0);
    reach(7'h3a);
    tick(30);
    chk("blank end", bl, 1'b0);
    chk("switching on", sw, 1'b1);
    th = 1;
    tick(5);
    chk("latch thermal", fl, 1'b1);
    reach(DAC_ZERO);
    toggle_en();
    chk("latch hot", fl, 1'b1);
    th = 0;
    toggle_en();
    chk("latch cooled", fl, 1'b0);
    reach(7'h3a);
    tick(30);
    ov = 1;
    tick(8);
    chk("latch ov off", fl, 1'b0);
    overvoltage_protect = 1;
    tick(5);
    chk("latch ov", fl, 1'b1);
    ov = 0;
    rst_n = 0;
    tick(3);
    chk("latch reset", fl, 1'b0);
    rst_n = 1;
    th = 1;
    tick(8);
    chk("latch thermal 2", fl, 1'b1);
    hv = 1;
    tick(5);
    chk("latch test", fl, 1'b0);
    chk("test mode", tm, 1'b1);
    chk("overlap", ol, 1'b0);
    uv = 1;
    ov = 1;
    tick(60);
    chk("latch in test", fl, 1'b0);
    end_sim();
  end
endmodule : tb
`default_nettype wire

// ==== dv/vcfs_host.sv ====
// partner model: processor vid outputs and system enable logic
`timescale 1ns/1ps
`default_nettype none
module vcfs_host (
  input  wire logic       battery_ok_in,
  input  wire logic       want_on_in,
  input  wire logic [4:0] code_in,
  input  wire logic [1:0] sleep_in,
  input  wire logic [3:0] sel_in,
  output logic [4:0]      vid_out,
  output logic [1:0]      sleep_out,
  output logic [1:0]      major_out,
  output logic [1:0]      minor_out,
  output logic            enable_out
);
  // enable held low until the battery is up, else startup may fail
  assign enable_out = want_on_in & battery_ok_in;
  assign vid_out    = code_in;
  assign sleep_out  = sleep_in;
  assign {major_out, minor_out} = sel_in;
endmodule : vcfs_host
`default_nettype wire

// ==== logic/vcfs_core.sv ====
// vid code decode, fault latch and soft-shutdown sequencer
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module vcfs_core
  import vcfs_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [4:0]       vid_code_bits_in,
  input  wire logic [1:0]       suspend_select_minor_in,
  input  wire logic [1:0]       suspend_select_major_in,
  input  wire logic [1:0]       sleep_range_input_in,
  input  wire logic             enable_n_pin_in,
  input  wire logic             test_hv_detect_in,
  input  wire logic             overvoltage_protect_in,
  input  wire logic             ov_fault_in,
  input  wire logic             uv_fault_in,
  input  wire logic             thermal_flag_in,
  output logic [vcfs_pkg::DAC_W-1:0] dac_code_out,
  output logic                  fault_latch_out,
  output logic                  test_mode_out,
  output logic                  overlap_en_out,
  output logic                  uv_blank_out,
  output logic [1:0]            low_side_gate_out,
  output logic [1:0]            high_side_gate_out,
  output logic                  switching_out
);
  import vcfs_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SW = 17;
  logic [SW-1:0] raw, s1, s2;
  assign raw = {vid_code_bits_in, suspend_select_minor_in,
                suspend_select_major_in, sleep_range_input_in,
                enable_n_pin_in, test_hv_detect_in, overvoltage_protect_in,
                ov_fault_in, uv_fault_in, thermal_flag_in};
  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    s1 <= raw;
    s2 <= s1;
  end

  logic [4:0] vid;
  logic [1:0] s_min, s_maj, sleep_range_input;
  logic       en, hv, ovp_on, ov, uv, hot;
  assign {vid, s_min, s_maj, sleep_range_input, en, hv, ovp_on, ov, uv, hot} = s2;

  // ---------------------------------------------------------------
  // target decode
  // ---------------------------------------------------------------
  function automatic logic [6:0] vcfs_target(input logic [4:0] v,
      input logic [1:0] su, input logic [1:0] mj, input logic [1:0] mn);
    logic [6:0] t;
    t = DAC_ZERO;
    if (su == SUS_GND) begin
      if (v != VID_OFF)
        t = VID_TOP - {2'h0, v};
    end else begin
      t = ((su == SUS_HIGH) ? SUS_LOW_BASE : SUS_UP_BASE)
          + {3'h0, mj, mn};
    end
    return t;
  endfunction : vcfs_target

  logic [6:0] target;
  assign target = vcfs_target(vid, sleep_range_input, s_maj, s_min);

  // ---------------------------------------------------------------
  // test mode and fault latch
  // ---------------------------------------------------------------
  logic test_d, en_d, hot_fault, low_seen;
  assign test_mode_out  = hv;
  assign overlap_en_out = ~hv;

  logic uv_hit, ov_hit, th_hit, fault_set;
  assign uv_hit = uv & ~uv_blank_out & ~hv;
  assign ov_hit = ov & ovp_on & ~hv;
  assign th_hit = hot & ~hv;
  assign fault_set = switching_out & (uv_hit | ov_hit | th_hit);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      test_d <= 1'b0;
      en_d   <= 1'b0;
    end else begin
      test_d <= hv;
      en_d   <= en;
    end
  end

  // clear needs enable low then high or test-mode entry; an enable edge does not clear a thermal fault while still hot
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fault_latch_out <= 1'b0;
      hot_fault       <= 1'b0;
      low_seen        <= 1'b0;
    end else if (fault_set) begin
      fault_latch_out <= 1'b1;
      hot_fault       <= hot_fault | th_hit;
      low_seen        <= 1'b0;
    end else if (hv & ~test_d) begin
      fault_latch_out <= 1'b0;
      hot_fault       <= 1'b0;
    end else if (fault_latch_out) begin
      if (!en)
        low_seen <= 1'b1;
      if (low_seen & en & ~en_d & ~(hot_fault & hot)) begin
        fault_latch_out <= 1'b0;
        hot_fault       <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // slew controller and blanking
  // ---------------------------------------------------------------
  logic [6:0] goal;
  logic [4:0] blank_cnt;
  // a held enable after the restart edge ramps up from the present dac code
  assign goal = (en & ~fault_latch_out) ? target : DAC_ZERO;
  assign switching_out = (dac_code_out != DAC_ZERO) |
                         (en & ~fault_latch_out & (target != DAC_ZERO));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      dac_code_out <= DAC_ZERO;
    else if (dac_code_out < goal)
      dac_code_out <= dac_code_out + 7'h01;
    else if (dac_code_out > goal)
      dac_code_out <= dac_code_out - 7'h01;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      blank_cnt <= BLANK_LOAD;
    else if (dac_code_out != goal)
      blank_cnt <= BLANK_LOAD;
    else if (blank_cnt != 5'h00)
      blank_cnt <= blank_cnt - 5'h01;
  end
  assign uv_blank_out = (dac_code_out != goal) | (blank_cnt != 5'h00);

  // gates forced only once a fault ramp has reached 0 V
  logic parked;
  assign parked = fault_latch_out & (dac_code_out == DAC_ZERO);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_side_gate_out  <= 2'h0;
      high_side_gate_out <= 2'h0;
    end else begin
      low_side_gate_out  <= parked ? 2'h3 : 2'h0;
      high_side_gate_out <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence fault_now;
    fault_set;
  endsequence
  sequence latch_up;
    ##1 fault_latch_out;
  endsequence
  a_fault_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fault_now |-> latch_up) else $error("fault did not latch");
  a_thermal_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    switching_out & hot & ~hv |=> fault_latch_out)
    else $error("thermal not latched");
  a_ov_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ov & ~ovp_on & ~uv & ~hot & ~fault_latch_out |=> ~fault_latch_out)
    else $error("ov latched while off");
  a_test_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    hv & ~test_d |=> ~fault_latch_out) else $error("test kept fault");
  a_test_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    hv & test_d & ~fault_latch_out |=> ~fault_latch_out)
    else $error("fault in test");
  a_latch_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fault_latch_out & ~(en & ~en_d) & ~hv |=> fault_latch_out)
    else $error("latch cleared early");
  a_hot_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fault_latch_out & hot_fault & hot & ~hv |=> fault_latch_out)
    else $error("cleared while hot");
  a_one_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dac_code_out != goal |=>
      (dac_code_out - $past(dac_code_out) == 7'h01) ||
      ($past(dac_code_out) - dac_code_out == 7'h01))
    else $error("slew not one step");
  a_blank_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(dac_code_out != goal) |-> blank_cnt == BLANK_LOAD)
    else $error("blank not reloaded");
  a_park_gates: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    parked |=> low_side_gate_out == 2'h3 && high_side_gate_out == 2'h0)
    else $error("gates not parked");
  a_vid_decode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sleep_range_input == SUS_GND && vid == 5'h1e |-> target == 7'h20)
    else $error("0.800 V decode wrong");
endmodule : vcfs_core
`default_nettype wire

// ==== logic/vcfs_pkg.sv ====
// package: constants and types for the vid code fault sequencer
package vcfs_pkg;
  localparam int unsigned DAC_W        = 7;
  // dac index counts 25 mV steps above 0 V; 1.550 V is 62 steps
  localparam logic [6:0]  DAC_ZERO     = 7'h00;
  localparam logic [6:0]  VID_TOP      = 7'h3e;  // 1.550 V
  localparam logic [6:0]  SUS_LOW_BASE = 7'h1b;  // 0.675 V
  localparam logic [6:0]  SUS_UP_BASE  = 7'h2b;  // 1.075 V
  localparam logic [4:0]  VID_OFF      = 5'h1f;  // shutdown code
  localparam int unsigned BLANK_CYC    = 24;
  localparam logic [4:0]  BLANK_LOAD   = 5'h18;
  // levels of the three- and four-level inputs from their comparators
  typedef enum logic [1:0] {LVL_GND, LVL_REF, LVL_OPEN, LVL_VCC} vcfs_lvl_e;
  typedef enum logic [1:0] {SUS_GND, SUS_REF, SUS_HIGH} vcfs_sus_e;
endpackage : vcfs_pkg
